// >>> design/nbp_consts.svh
`ifndef NBP_CONSTS_SVH
`define NBP_CONSTS_SVH
// Command codes
`define NBP_CMD_UNPROT_LO   8'h23
`define NBP_CMD_UNPROT_HI   8'h24
`define NBP_CMD_PROT_ALL    8'h2A
`define NBP_CMD_SOLID       8'h2C
`define NBP_CMD_STATUS      8'h70
`define NBP_CMD_PROT_STAT   8'h7A
// Status answers
`define NBP_STAT_REJECT     8'h60
`define NBP_UNPROT_BIT      2
`define NBP_LOCK_N_BIT      1
`define NBP_LOCK_BIT        0
// Address cycle layout, byte-wide
`define NBP_X8_C1_SHIFT     6
`define NBP_X8_C3_SHIFT     8
`define NBP_X8_C2_LSB       2
// Address cycle layout, word-wide
`define NBP_X16_C1_SHIFT    6
`define NBP_X16_C2_LSB      2
`define NBP_X16_C3_SHIFT    8
// Timing in ns, counts derived at 25 MHz
`define NBP_CLK_PERIOD_NS   40
`define NBP_T_WP_NS         12
`define NBP_T_WH_NS         10
`define NBP_T_WHR_NS        80
`define NBP_T_REA_NS        22
`define NBP_T_BUSY_MAX_NS   3000
`define NBP_T_WB_NS         100
`define NBP_CEIL(t)    (((t) + `NBP_CLK_PERIOD_NS - 1) / `NBP_CLK_PERIOD_NS)
`define NBP_CYC_MIN(t) (`NBP_CEIL(t) < 1 ? 1 : `NBP_CEIL(t))
`endif

// >>> design/nbp_pkg.sv
package nbp_pkg;
  // Host operations accepted at the user port
  typedef enum logic [2:0] {
    NBP_OP_UNPROT  = 3'h0,
    NBP_OP_PROTALL = 3'h1,
    NBP_OP_SOLID   = 3'h2,
    NBP_OP_QUERY   = 3'h3,
    NBP_OP_STATUS  = 3'h4
  } nbp_op_t;
  // Kind of bus cycle issued by the cycle engine
  typedef enum logic [1:0] {
    NBP_CY_CMD  = 2'h0,
    NBP_CY_ADDR = 2'h1,
    NBP_CY_READ = 2'h2
  } nbp_cy_t;
endpackage

// >>> design/nbp_cycle.sv
`timescale 1ns/100ps
`include "nbp_consts.svh"
// One bus cycle: command or address write, or data read, on the flash pins
module nbp_cycle (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Request
  input  wire logic           start,
  input  wire nbp_pkg::nbp_cy_t kind,
  input  wire logic [15:0]    wdata,
  output logic                done,
  output logic [15:0]         rdata,
  // Pin drive
  output logic                cle,
  output logic                ale,
  output logic                we_n,
  output logic                re_n,
  output logic [15:0]         io_o,
  output logic                io_oe,
  // Synchronised data in
  input  wire logic [15:0]    io_sync
);
  import nbp_pkg::*;
  localparam int WP_C = `NBP_CYC_MIN(`NBP_T_WP_NS);
  localparam int WH_C = `NBP_CYC_MIN(`NBP_T_WH_NS);
  // Read strobe held long enough for access time plus the three-stage sync
  localparam int RD_C = `NBP_CYC_MIN(`NBP_T_REA_NS) + 3;
  localparam int PRE_C = `NBP_CYC_MIN(`NBP_T_WHR_NS);
  typedef enum logic [1:0] {
    NBP_C_IDLE = 2'b00,
    NBP_C_STRB = 2'b01,
    NBP_C_HOLD = 2'b10,
    NBP_C_PRE  = 2'b11
  } nbp_cst_t;
  nbp_cst_t    st_q;
  logic [3:0]  cnt_q;
  nbp_cy_t     kind_q;
  wire         cnt_zero = (cnt_q == 4'h0);
  wire         is_read  = (kind_q == NBP_CY_READ);
  // Sequencer: write-to-read gap, strobe low, then recovery high time
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= NBP_C_IDLE;
      cnt_q <= 4'h0;
      kind_q <= NBP_CY_CMD;
      done <= 1'b0;
      rdata <= 16'h0000;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_o <= 16'h0000;
      io_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      unique case (st_q)
        NBP_C_IDLE: if (start) begin
          kind_q <= kind;
          cle <= (kind == NBP_CY_CMD);
          ale <= (kind == NBP_CY_ADDR);
          io_o <= wdata;
          io_oe <= (kind != NBP_CY_READ);
          st_q <= (kind == NBP_CY_READ) ? NBP_C_PRE : NBP_C_STRB;
          cnt_q <= (kind == NBP_CY_READ) ? 4'(PRE_C) : 4'h0;
        end
        NBP_C_PRE: if (cnt_zero) begin
          st_q <= NBP_C_STRB;
        end
        NBP_C_STRB: begin
          if (cnt_q == 4'h0 && we_n && re_n) begin
            we_n <= is_read;
            re_n <= !is_read;
            cnt_q <= 4'(is_read ? RD_C : WP_C);
          end else if (cnt_zero) begin
            if (is_read) rdata <= io_sync;
            we_n <= 1'b1;
            re_n <= 1'b1;
            cnt_q <= 4'(WH_C);
            st_q <= NBP_C_HOLD;
          end
        end
        NBP_C_HOLD: if (cnt_zero) begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          done <= 1'b1;
          st_q <= NBP_C_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> design/nbp_host.sv
`timescale 1ns/100ps
`include "nbp_consts.svh"
module nbp_host #(
  parameter int BLK_W = 12
) (
  // Clock and reset
  input  wire logic             MCLK,
  input  wire logic             RST_N,
  // User orders
  input  wire logic             REQ,
  input  wire nbp_pkg::nbp_op_t OP,
  input  wire logic             WIDE,
  input  wire logic [BLK_W-1:0] BLK_LO,
  input  wire logic [BLK_W-1:0] BLK_HI,
  input  wire logic             INVERT,
  output logic                  BUSY,
  output logic                  DONE,
  output logic [7:0]            RESULT,
  output logic                  BLOCK_UNPROTECTED,
  output logic                  SOLID_LOCK,
  output logic                  SOLID_LOCK_N,
  output logic                  REJECTED,
  output logic                  RB_TIMEOUT,
  // Flash pins
  output logic                  CE_N,
  output logic                  CLE,
  output logic                  ALE,
  output logic                  WE_N,
  output logic                  RE_N,
  output logic                  WP_N,
  output logic [15:0]           IO_O,
  output logic                  IO_OE,
  input  wire logic [15:0]      IO_I,
  input  wire logic             RB_N
);
  import nbp_pkg::*;
  localparam int BUSY_C = `NBP_CYC_MIN(`NBP_T_BUSY_MAX_NS);
  localparam int WB_C   = `NBP_CYC_MIN(`NBP_T_WB_NS);
  typedef enum logic [3:0] {
    NBP_IDLE = 4'h0,
    NBP_CMD1 = 4'h1,
    NBP_ADR  = 4'h2,
    NBP_CMD2 = 4'h3,
    NBP_ADR2 = 4'h4,
    NBP_RD   = 4'h5,
    NBP_WAIT = 4'h6,
    NBP_FIN  = 4'h7
  } nbp_st_t;
  nbp_st_t     st_q;
  nbp_op_t     op_q;
  logic [1:0]  acyc_q;
  logic [7:0]  tmr_q;
  logic        wide_q, inv_q, cy_start_q;
  logic [BLK_W-1:0] lo_q, hi_q;
  nbp_cy_t     cy_kind_q;
  logic [15:0] cy_wdata_q;
  logic        cy_done;
  logic [15:0] cy_rdata;
  logic [15:0] io_s1_q, io_s2_q, io_s3_q;
  logic        rb_s1_q, rb_s2_q, rb_s3_q, rb_q;
  // Pin inputs: three stages, a ready change counts when stages two and three agree
  always_ff @(posedge MCLK) begin
    io_s1_q <= IO_I;
    io_s2_q <= io_s1_q;
    io_s3_q <= io_s2_q;
    rb_s1_q <= RB_N;
    rb_s2_q <= rb_s1_q;
    rb_s3_q <= rb_s2_q;
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N) rb_q <= 1'b1;
    else if (rb_s2_q == rb_s3_q) rb_q <= rb_s3_q;
  end
  // Upper phase starts while 24h is on the bus: its first byte is built then
  wire             upper = (st_q == NBP_CMD2) || (st_q == NBP_ADR2);
  wire [BLK_W-1:0] blk = upper ? hi_q : lo_q;
  // Invert only on the upper command; low on the lower one
  wire             inv_bit = upper && inv_q;
  wire [31:0] blk32 = 32'(blk);
  // Byte-wide: A19/A18 are block bits 1:0, A27..A20 bits 9:2, A29/A28 11:10
  wire [7:0] x8_c1 = {blk32[1:0], 5'h00, inv_bit};
  wire [7:0] x8_c2 = blk32[9:2];
  wire [7:0] x8_c3 = {6'h00, blk32[11:10]};
  // Word-wide: same block bits in the same address positions as byte-wide, upper byte low
  wire [7:0] x16_c1 = {blk32[1:0], 5'h00, inv_bit};
  wire [7:0] x16_c2 = blk32[9:2];
  wire [7:0] x16_c3 = {6'h00, blk32[11:10]};
  wire [7:0] acyc_byte = (acyc_q == 2'h0) ? (wide_q ? x16_c1 : x8_c1) :
                         (acyc_q == 2'h1) ? (wide_q ? x16_c2 : x8_c2) :
                                            (wide_q ? x16_c3 : x8_c3);
  // Command code of the first phase, decoded as the order is taken
  wire [7:0] cmd1 = (OP == NBP_OP_UNPROT)  ? `NBP_CMD_UNPROT_LO :
                    (OP == NBP_OP_PROTALL) ? `NBP_CMD_PROT_ALL :
                    (OP == NBP_OP_SOLID)   ? `NBP_CMD_SOLID :
                    (OP == NBP_OP_QUERY)   ? `NBP_CMD_PROT_STAT :
                                             `NBP_CMD_STATUS;
  wire has_addr = (op_q == NBP_OP_UNPROT) || (op_q == NBP_OP_QUERY);
  wire has_read = (op_q == NBP_OP_QUERY) || (op_q == NBP_OP_STATUS);
  // Upper byte held zero on every command write
  wire [15:0] cmd1_w = {8'h00, cmd1};
  wire [15:0] cmd2_w = {8'h00, `NBP_CMD_UNPROT_HI};
  wire [15:0] adr_w  = {8'h00, acyc_byte};
  wire last_adr = (acyc_q == 2'h2);
  // Protection status decode of the answer byte
  wire r_unp    = cy_rdata[`NBP_UNPROT_BIT];
  wire r_lock   = cy_rdata[`NBP_LOCK_BIT];
  wire r_lock_n = cy_rdata[`NBP_LOCK_N_BIT];
  // Rejected program/erase shows as 60h on a plain status read
  wire r_rej = (cy_rdata[7:0] == `NBP_STAT_REJECT);

  nbp_cycle u_cycle (
    .clk     (MCLK),
    .rst_n   (RST_N),
    .start   (cy_start_q),
    .kind    (cy_kind_q),
    .wdata   (cy_wdata_q),
    .done    (cy_done),
    .rdata   (cy_rdata),
    .cle     (CLE),
    .ale     (ALE),
    .we_n    (WE_N),
    .re_n    (RE_N),
    .io_o    (IO_O),
    .io_oe   (IO_OE),
    .io_sync (io_s3_q)
  );

  // Sequence: command, address cycles, upper command and its address cycles, then read or busy wait
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      st_q <= NBP_IDLE;
      op_q <= NBP_OP_STATUS;
      acyc_q <= 2'h0;
      tmr_q <= 8'h00;
      wide_q <= 1'b0;
      inv_q <= 1'b0;
      lo_q <= '0;
      hi_q <= '0;
      cy_start_q <= 1'b0;
      cy_kind_q <= NBP_CY_CMD;
      cy_wdata_q <= 16'h0000;
      BUSY <= 1'b0;
      DONE <= 1'b0;
      RESULT <= 8'h00;
      BLOCK_UNPROTECTED <= 1'b0;
      SOLID_LOCK <= 1'b0;
      SOLID_LOCK_N <= 1'b1;
      REJECTED <= 1'b0;
      RB_TIMEOUT <= 1'b0;
      CE_N <= 1'b1;
      WP_N <= 1'b0;
    end else begin
      cy_start_q <= 1'b0;
      DONE <= 1'b0;
      if (tmr_q != 8'h00) tmr_q <= tmr_q - 8'h01;
      unique case (st_q)
        NBP_IDLE: if (REQ) begin
          op_q <= OP;
          wide_q <= WIDE;
          lo_q <= BLK_LO;
          hi_q <= BLK_HI;
          inv_q <= INVERT;
          // Write-protect released ahead of any protection command
          WP_N <= 1'b1;
          CE_N <= 1'b0;
          BUSY <= 1'b1;
          RB_TIMEOUT <= 1'b0;
          st_q <= NBP_CMD1;
          // Address counter left at 2 by the last order with address cycles; first byte needs 0
          acyc_q <= 2'h0;
          cy_kind_q <= NBP_CY_CMD;
          cy_start_q <= 1'b1;
          cy_wdata_q <= cmd1_w;
        end
        NBP_CMD1: if (cy_done) begin
          acyc_q <= 2'h0;
          if (has_addr) begin
            st_q <= NBP_ADR;
            cy_kind_q <= NBP_CY_ADDR;
            cy_start_q <= 1'b1;
            cy_wdata_q <= adr_w;
          end else if (has_read) begin
            st_q <= NBP_RD;
            cy_kind_q <= NBP_CY_READ;
            cy_start_q <= 1'b1;
          end else begin
            // Protect-all and solid-protect end once the device is ready
            tmr_q <= 8'(BUSY_C + WB_C);
            st_q <= NBP_WAIT;
          end
        end
        NBP_ADR, NBP_ADR2: if (cy_done) begin
          if (!last_adr) begin
            acyc_q <= acyc_q + 2'h1;
            cy_kind_q <= NBP_CY_ADDR;
            cy_start_q <= 1'b1;
            cy_wdata_q <= {8'h00, (acyc_q == 2'h0) ?
                           (wide_q ? x16_c2 : x8_c2) :
                           (wide_q ? x16_c3 : x8_c3)};
          end else if (st_q == NBP_ADR && op_q == NBP_OP_UNPROT) begin
            // Upper command follows lower without anything between
            acyc_q <= 2'h0;
            st_q <= NBP_CMD2;
            cy_kind_q <= NBP_CY_CMD;
            cy_start_q <= 1'b1;
            cy_wdata_q <= cmd2_w;
          end else if (op_q == NBP_OP_QUERY) begin
            st_q <= NBP_RD;
            cy_kind_q <= NBP_CY_READ;
            cy_start_q <= 1'b1;
          end else begin
            tmr_q <= 8'(BUSY_C + WB_C);
            st_q <= NBP_WAIT;
          end
        end
        NBP_CMD2: if (cy_done) begin
          st_q <= NBP_ADR2;
          cy_kind_q <= NBP_CY_ADDR;
          cy_start_q <= 1'b1;
          cy_wdata_q <= {8'h00, wide_q ? x16_c1 : x8_c1};
        end
        NBP_RD: if (cy_done) begin
          RESULT <= cy_rdata[7:0];
          if (op_q == NBP_OP_QUERY) begin
            BLOCK_UNPROTECTED <= r_unp;
            SOLID_LOCK <= r_lock;
            SOLID_LOCK_N <= r_lock_n;
          end else begin
            REJECTED <= r_rej;
          end
          st_q <= NBP_FIN;
        end
        NBP_WAIT: begin
          // Device busy stays under its bound; longer counts as a fault
          if (tmr_q == 8'h00) begin
            RB_TIMEOUT <= !rb_q;
            st_q <= NBP_FIN;
          end else if (rb_q && tmr_q < 8'(BUSY_C)) begin
            st_q <= NBP_FIN;
          end
        end
        NBP_FIN: begin
          CE_N <= 1'b1;
          BUSY <= 1'b0;
          DONE <= 1'b1;
          st_q <= NBP_IDLE;
        end
        default: st_q <= NBP_IDLE;
      endcase
    end
  end
endmodule

// >>> verification/nbp_host_monitor.sv
`timescale 1ns/100ps
// Pin-level checks on the host, all in the one clock domain
module nbp_host_monitor (
  // Clock and reset
  input wire logic        MCLK,
  input wire logic        RST_N,
  // User side
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic        BLOCK_UNPROTECTED,
  input wire logic        SOLID_LOCK,
  input wire logic        SOLID_LOCK_N,
  input wire logic        RB_TIMEOUT,
  // Flash pins
  input wire logic        CE_N,
  input wire logic        CLE,
  input wire logic        ALE,
  input wire logic        WE_N,
  input wire logic        RE_N,
  input wire logic        WP_N,
  input wire logic [15:0] IO_O,
  input wire logic        IO_OE,
  input wire logic        RB_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [6:0] lo_cnt_q;
  // Busy cycles with ready low; saturates so it never wraps
  always_ff @(posedge MCLK) begin
    if (!RST_N || !BUSY || RB_N) lo_cnt_q <= 7'h00;
    else if (lo_cnt_q != 7'h7F) lo_cnt_q <= lo_cnt_q + 7'h01;
  end
  property p_upper_zero;
    IO_OE |-> IO_O[15:8] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper data byte not low");
  property p_solid_wp;
    CLE && !WE_N && IO_O[7:0] == 8'h2C |-> WP_N;
  endproperty
  a_solid_wp: assert property (p_solid_wp)
    else $error("solid command with write protect low");
  property p_flag_pair;
    SOLID_LOCK_N == !SOLID_LOCK;
  endproperty
  a_flag_pair: assert property (p_flag_pair)
    else $error("lock flags not complementary");
  property p_strobe;
    !WE_N |-> !CE_N && IO_OE && (CLE ^ ALE);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("write strobe without qualified cycle");
  property p_we_pulse;
    $fell(WE_N) |=> ##1 $rose(WE_N);
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe not two cycles");
  property p_read;
    !RE_N |-> !CE_N && !IO_OE && !CLE && !ALE;
  endproperty
  a_read: assert property (p_read)
    else $error("read strobe during drive");
  property p_done_ready;
    DONE && !RB_TIMEOUT |-> RB_N;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("order ended while flash busy");
  property p_wait_bound;
    lo_cnt_q < 7'h64;
  endproperty
  a_wait_bound: assert property (p_wait_bound)
    else $error("busy wait beyond window");
  c_solid: cover property ($rose(SOLID_LOCK));
  c_timeout: cover property ($rose(RB_TIMEOUT));
  c_unprot: cover property ($rose(BLOCK_UNPROTECTED));
endmodule
bind nbp_host nbp_host_monitor i_mon (.MCLK, .RST_N, .BUSY, .DONE,
  .BLOCK_UNPROTECTED, .SOLID_LOCK, .SOLID_LOCK_N, .RB_TIMEOUT, .CE_N,
  .CLE, .ALE, .WE_N, .RE_N, .WP_N, .IO_O, .IO_OE, .RB_N);

// >>> verification/nbp_flash_model.sv
`timescale 1ns/100ps
// Behavioural flash die, protection commands and the 70h status read only
module nbp_flash_model (
  // Power and test controls
  input  wire logic        por,
  input  wire logic        strap,
  input  wire logic [1:0]  slow,
  // Flash pins
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        re_n,
  input  wire logic        wp_n,
  input  wire logic [15:0] io_o,
  output logic      [15:0] io_i,
  output logic             rb_n,
  output logic             inv_on_lo
);
  logic        prot [4096];
  logic        en, solid, rdy, inv, rej;
  logic [7:0]  cmd, rd;
  logic [7:0]  a [3];
  logic [11:0] lo, hi, blk;
  int          n;
  event        go;
  // Ready driven straight from the die, both high and low; no pull-up
  assign rb_n = rdy;
  // Released bus shows the inverse, so stale data never passes
  assign io_i = (!ce_n && !re_n) ? {8'h00, rd} : ~{8'h00, rd};
  // Power-on: strap picks enable and default state
  always @(posedge por) begin
    en = strap;
    solid = 1'b0;
    rej = 1'b0;
    rdy = 1'b1;
    inv_on_lo = 1'b0;
    rd = 8'h00;
    foreach (prot[i]) prot[i] = strap;
  end
  // Commands and addresses latch on the write strobe
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd = io_o[7:0];
      n = 0;
      if (cmd == 8'h2A && en && !solid) begin
        foreach (prot[i]) prot[i] = 1'b1;
      end
      if (cmd == 8'h2C && en && wp_n) solid = 1'b1;
      // Refused change under the lock stands in for a rejected write
      if (cmd == 8'h2A && en && solid) rej = 1'b1;
      if (cmd == 8'h2A || cmd == 8'h2C) -> go;
      if (cmd == 8'h70) rd = rej ? 8'h60 : 8'hE0;
    end else if (ale && n < 3) begin
      a[n] = io_o[7:0];
      n = n + 1;
      if (n == 3) begin
        blk = {a[2][1:0], a[1], a[0][7:6]};
        if (cmd == 8'h23) begin
          lo = blk;
          inv_on_lo = inv_on_lo | a[0][0];
        end
        if (cmd == 8'h24) begin
          hi = blk;
          inv = a[0][0];
          if (en && solid) rej = 1'b1;
          if (en && !solid) begin
            foreach (prot[i]) begin
              if ((i >= lo && i <= hi) ^ inv) prot[i] = 1'b0;
            end
          end
          -> go;
        end
        if (cmd == 8'h7A) rd = {5'h00, !prot[blk], !solid, solid};
      end
    end
  end
  // Busy pulse; slow setting 2 overruns the limit on purpose
  always @(go) begin
    #50 rdy = 1'b0;
    #(slow == 2'h0 ? 200 : slow == 2'h1 ? 2400 : 4000);
    rdy = 1'b1;
  end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/100ps
// Orders into the host, protection state checked through queries
module testbench;
  import nbp_pkg::*;
  logic        mclk, rst_n, req, wide, inv, busy, done, blk_unp;
  logic        solid, solid_n, rej, rb_to, ce_n, cle, ale, we_n;
  logic        re_n, wp_n, io_oe, rb_n, por, strap, inv_lo;
  logic [1:0]  slow;
  logic [7:0]  result;
  logic [11:0] blo, bhi;
  logic [15:0] io_o, io_i;
  nbp_op_t     op;
  int          errors, checked;
  nbp_host #(.BLK_W(12)) i_dut (.MCLK(mclk), .RST_N(rst_n), .REQ(req),
    .OP(op), .WIDE(wide), .BLK_LO(blo), .BLK_HI(bhi), .INVERT(inv),
    .BUSY(busy), .DONE(done), .RESULT(result), .BLOCK_UNPROTECTED(blk_unp),
    .SOLID_LOCK(solid), .SOLID_LOCK_N(solid_n), .REJECTED(rej),
    .RB_TIMEOUT(rb_to), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n),
    .RE_N(re_n), .WP_N(wp_n), .IO_O(io_o), .IO_OE(io_oe), .IO_I(io_i),
    .RB_N(rb_n));
  nbp_flash_model i_flash (.por(por), .strap(strap), .slow(slow),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .io_o(io_o), .io_i(io_i), .rb_n(rb_n),
    .inv_on_lo(inv_lo));
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Verdict and counts
  task automatic end_sim;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compare one byte-wide result
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // One order; a hang counts as a mismatch
  task automatic run(input nbp_op_t o, input logic w, input logic [11:0] l,
                     input logic [11:0] h, input logic iv);
    int k;
    @(negedge mclk);
    req = 1'b1;
    op = o;
    wide = w;
    blo = l;
    bhi = h;
    inv = iv;
    @(negedge mclk);
    req = 1'b0;
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(negedge mclk);
    if (done !== 1'b1) begin
      errors++;
      end_sim();
    end
  endtask
  // Query one block, check status byte and flags
  task automatic query(input logic [11:0] b, input logic u, input logic s);
    run(NBP_OP_QUERY, 1'b0, b, 12'h000, 1'b0);
    cmp(result, {5'h00, u, !s, s});
    cmp({7'h00, blk_unp}, {7'h00, u});
    cmp({6'h00, solid, solid_n}, {6'h00, s, !s});
    cmp({7'h00, busy}, 8'h00);
  endtask
  initial begin
    errors = 0;
    checked = 0;
    rst_n = 1'b0;
    req = 1'b0;
    op = NBP_OP_STATUS;
    wide = 1'b0;
    blo = 12'h000;
    bhi = 12'h000;
    inv = 1'b0;
    por = 1'b0;
    strap = 1'b1;
    slow = 2'h1;
    #1 por = 1'b1;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    query(12'h000, 1'b0, 1'b0);
    query(12'hFFF, 1'b0, 1'b0);
    run(NBP_OP_UNPROT, 1'b0, 12'h005, 12'h00A, 1'b0);
    cmp({7'h00, rb_to}, 8'h00);
    slow = 2'h0;
    query(12'h004, 1'b0, 1'b0);
    query(12'h005, 1'b1, 1'b0);
    query(12'h00A, 1'b1, 1'b0);
    query(12'h00B, 1'b0, 1'b0);
    run(NBP_OP_PROTALL, 1'b0, 12'h000, 12'h000, 1'b0);
    query(12'h005, 1'b0, 1'b0);
    run(NBP_OP_UNPROT, 1'b1, 12'h005, 12'h00A, 1'b1);
    query(12'h004, 1'b1, 1'b0);
    query(12'h00A, 1'b0, 1'b0);
    query(12'hFFF, 1'b1, 1'b0);
    cmp({7'h00, inv_lo}, 8'h00);
    run(NBP_OP_STATUS, 1'b0, 12'h000, 12'h000, 1'b0);
    cmp(result, 8'hE0);
    cmp({7'h00, rej}, 8'h00);
    run(NBP_OP_SOLID, 1'b0, 12'h000, 12'h000, 1'b0);
    query(12'h004, 1'b1, 1'b1);
    run(NBP_OP_PROTALL, 1'b0, 12'h000, 12'h000, 1'b0);
    query(12'h004, 1'b1, 1'b1);
    run(NBP_OP_UNPROT, 1'b0, 12'h005, 12'h00A, 1'b0);
    query(12'h005, 1'b0, 1'b1);
    run(NBP_OP_STATUS, 1'b0, 12'h000, 12'h000, 1'b0);
    cmp(result, 8'h60);
    cmp({7'h00, rej}, 8'h01);
    slow = 2'h2;
    run(NBP_OP_PROTALL, 1'b0, 12'h000, 12'h000, 1'b0);
    cmp({7'h00, rb_to}, 8'h01);
    // Power cycle the die with the strap low
    slow = 2'h0;
    strap = 1'b0;
    por = 1'b0;
    @(negedge mclk);
    por = 1'b1;
    run(NBP_OP_PROTALL, 1'b0, 12'h000, 12'h000, 1'b0);
    query(12'h007, 1'b1, 1'b0);
    run(NBP_OP_SOLID, 1'b0, 12'h000, 12'h000, 1'b0);
    query(12'h007, 1'b1, 1'b0);
    end_sim();
  end
endmodule
